// ==== rtl/mcb_buffer.sv ====
// Behaviour
// - Sixteen entries of twelve bits: data byte, parity, three flags.
// - Sequencer writes from counter bits 7:0 and 11:9; reads go to I/O or counter.
// - Holding register captures reads; low byte loadable from I/O byte.
// - Four-bit pointer to next command entry.
// - Four-bit bound marking highest command entry.
// - Four-bit pointer to next data entry.
// - Four-bit lowest data entry bound.
// - One step unit updates both pointers.
// - Count preset loads from rotaries or counter, then moves to down counter.
// - Down counter counts fetched data bytes; also a utility counter.
// - Display: data byte on group A; parity, flags, step value on B.
// - Panel load writes right digits and flags, or all digits to preset.
// - Set-address loads step unit plus command pointer, lower or upper bound.
// - Halt on miscompare during forward and backward reads only.
// - Compare source: pointed entry, all zeros or all ones.
// - Repeat current command until stop or switch off.
// - Counted loop: reset, optional delay, load start, count down, repeat.
// - Address loop: reset, optional delay, run until address matches, repeat.
// - Preset zero gives a continuous record without count end.
// - Data runs lower bound through F and wraps until count ends.
// - Commands loop zero to bound unless stop flag; overlap doubles as data.
// - Parity corrupt control stores wrong parity.
// - Parity is odd over the data byte.
// - Flags: stop after command, unit address, branch word.
// - Command pointer steps by one, back to zero at the bound.
module mcb_buffer #(
  parameter logic [mcb_pkg::DLY_W-1:0] DELAY_CYC = mcb_pkg::LOOP_DELAY_CYC
) (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // Register port
  input  wire logic [3:0]                  reg_addr_i,
  input  wire logic [11:0]                 reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [11:0]                 reg_rdata_o,
  // Panel and sequencer
  input  wire mcb_pkg::mcb_panel_s         panel_i,
  input  wire mcb_pkg::mcb_micro_s         micro_i,
  input  wire logic [mcb_pkg::CNT_W-1:0]   general_counter_i,
  input  wire logic [mcb_pkg::DATA_W-1:0]  io_byte_i,
  // Data out
  output logic      [mcb_pkg::ENTRY_W-1:0] store_rd_data_o,
  output logic      [mcb_pkg::ENTRY_W-1:0] buffer_output_holding_o,
  output logic      [7:0]                  display_a_o,
  output logic      [7:0]                  display_b_o,
  // Status
  output logic                             miscompare_halt_o,
  output logic                             buffer_stop_o,
  output logic                             count_done_o,
  output logic                             repeat_active_o,
  // Microloop control
  output logic                             machine_reset_o,
  output logic                             uaddr_load_o,
  output logic      [mcb_pkg::UADDR_W-1:0] uaddr_value_o
);
  logic [11:0] store [mcb_pkg::NUM_ENTRIES];
  logic [3:0]  next_command_pointer;
  logic [3:0]  last_command_bound;
  logic [3:0]  next_fetch_pointer;
  logic [3:0]  fetch_lowest_bound;
  logic [3:0]  step_value;
  logic [3:0]  step_operand;
  logic [3:0]  next_step;
  logic [11:0] byte_count_preset;
  logic [11:0] byte_down_counter;
  logic [11:0] loop_count;
  logic [23:0] delay_count;
  logic        continuous;
  logic        repeat_latch;
  logic        repeat_sw_q;
  logic        count_mode;
  logic        panel_wr;
  logic        fetch_go;
  logic        miscompare;
  logic        loop_sw;
  logic        set_buf;
  logic [11:0] src_entry;
  logic [11:0] cmd_entry;
  mcb_pkg::mcb_loop_e state;
  mcb_pkg::mcb_loop_e next_state;

  function automatic logic [11:0] make_entry(input logic [7:0] data,
                                             input logic [2:0] flags,
                                             input logic       corrupt);
    make_entry = {flags, ~(^data) ^ corrupt, data};
  endfunction : make_entry

  function automatic logic bus_wr(input logic [3:0] off);
    bus_wr = reg_wr_i && (reg_addr_i == off);
  endfunction : bus_wr

  assign panel_wr  = panel_i.load_pb && !panel_i.count_or_entry_load_select;
  assign set_buf   = panel_i.set_adr_pb && (panel_i.bound_target_select == mcb_pkg::BND_BUF);
  assign cmd_entry = store[next_command_pointer];
  assign count_done_o = !continuous && (byte_down_counter == mcb_pkg::CNT_RST);
  // Count end blocks further fetches; a halt freezes the compare registers
  assign fetch_go  = micro_i.data_fetch && !count_done_o && !miscompare_halt_o;

  always_comb begin
    case (panel_i.data_source)
      mcb_pkg::SRC_BUF:  src_entry = store[next_fetch_pointer];
      mcb_pkg::SRC_ZERO: src_entry = make_entry(mcb_pkg::BYTE_ZERO, 3'h0, 1'b0);
      mcb_pkg::SRC_ONES: src_entry = make_entry(mcb_pkg::BYTE_ONES, 3'h0, 1'b0);
      default:           src_entry = mcb_pkg::ENTRY_RST;
    endcase
  end

  assign miscompare = fetch_go && panel_i.halt_on_miscompare &&
                      (micro_i.read_fwd || micro_i.read_bwd) &&
                      (src_entry[7:0] != io_byte_i);

  // Store: panel wins the single write port
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < mcb_pkg::NUM_ENTRIES; i++) begin
        store[i] <= mcb_pkg::ENTRY_RST;
      end
    end else if (panel_wr) begin
      store[panel_i.left_rot] <= make_entry(panel_i.right_rot, panel_i.flag_sw,
                                            panel_i.parity_corrupt);
    end else if (micro_i.store_wr) begin
      store[micro_i.store_idx] <= make_entry(general_counter_i[7:0],
                                             general_counter_i[11:9],
                                             panel_i.parity_corrupt);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      store_rd_data_o <= mcb_pkg::ENTRY_RST;
    end else if (micro_i.store_rd) begin
      store_rd_data_o <= store[micro_i.store_idx];
    end
  end

  // Holding register stays frozen while a miscompare halt is shown
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buffer_output_holding_o <= mcb_pkg::ENTRY_RST;
    end else if (miscompare_halt_o) begin
      buffer_output_holding_o <= buffer_output_holding_o;
    end else if (micro_i.access_command) begin
      buffer_output_holding_o <= cmd_entry;
    end else if (fetch_go) begin
      buffer_output_holding_o <= src_entry;
    end else if (micro_i.store_rd) begin
      buffer_output_holding_o <= store[micro_i.store_idx];
    end else if (micro_i.hold_from_io) begin
      buffer_output_holding_o[7:0] <= io_byte_i;
    end else if (bus_wr(mcb_pkg::REG_HOLD)) begin
      buffer_output_holding_o <= reg_wdata_i;
    end
  end

  // One shared step unit; a command access takes precedence over a fetch
  assign step_operand = micro_i.access_command ? next_command_pointer : next_fetch_pointer;

  mcb_step_unit u_step (
    .value_i     (step_operand),
    .cmd_i       (micro_i.access_command),
    .down_i      (micro_i.read_bwd),
    .cmd_bound_i (last_command_bound),
    .data_low_i  (fetch_lowest_bound),
    .next_o      (next_step)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_value <= mcb_pkg::IDX_ZERO;
    end else if (set_buf) begin
      step_value <= panel_i.left_rot;
    end else if (micro_i.access_command || fetch_go) begin
      step_value <= next_step;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      next_command_pointer <= mcb_pkg::IDX_ZERO;
    end else if (set_buf) begin
      next_command_pointer <= panel_i.left_rot;
    end else if (micro_i.access_command && !repeat_latch) begin
      next_command_pointer <= next_step;
    end else if (bus_wr(mcb_pkg::REG_CMDPTR)) begin
      next_command_pointer <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_command_bound <= mcb_pkg::IDX_ZERO;
      fetch_lowest_bound <= mcb_pkg::IDX_ZERO;
    end else begin
      if (panel_i.set_adr_pb && panel_i.bound_target_select == mcb_pkg::BND_CMD_BOUND) begin
        last_command_bound <= panel_i.left_rot;
      end else if (bus_wr(mcb_pkg::REG_CMDUB)) begin
        last_command_bound <= reg_wdata_i[3:0];
      end
      if (panel_i.set_adr_pb && panel_i.bound_target_select == mcb_pkg::BND_FETCH_LOW) begin
        fetch_lowest_bound <= panel_i.left_rot;
      end else if (bus_wr(mcb_pkg::REG_DATLB)) begin
        fetch_lowest_bound <= reg_wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      next_fetch_pointer <= mcb_pkg::IDX_ZERO;
    end else if (fetch_go && !micro_i.access_command) begin
      next_fetch_pointer <= next_step;
    end else if (bus_wr(mcb_pkg::REG_DATPTR)) begin
      next_fetch_pointer <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_count_preset <= mcb_pkg::CNT_RST;
    end else if (panel_i.load_pb && panel_i.count_or_entry_load_select) begin
      byte_count_preset <= {panel_i.left_rot, panel_i.right_rot};
    end else if (micro_i.preset_from_gc) begin
      byte_count_preset <= general_counter_i;
    end else if (bus_wr(mcb_pkg::REG_PRESET)) begin
      byte_count_preset <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_down_counter <= mcb_pkg::CNT_RST;
      continuous        <= 1'b0;
    end else if (micro_i.preset_to_counter) begin
      byte_down_counter <= byte_count_preset;
      continuous        <= (byte_count_preset == mcb_pkg::CNT_RST);
    end else if ((fetch_go && !continuous) || micro_i.count_dec) begin
      byte_down_counter <= byte_down_counter - 12'h001;
    end else if (bus_wr(mcb_pkg::REG_COUNT)) begin
      byte_down_counter <= reg_wdata_i;
    end
  end

  // Halt and stop flags: a new event beats the start clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      miscompare_halt_o <= 1'b0;
      buffer_stop_o     <= 1'b0;
    end else begin
      if (miscompare) begin
        miscompare_halt_o <= 1'b1;
      end else if (panel_i.start_pb) begin
        miscompare_halt_o <= 1'b0;
      end
      if (micro_i.access_command && cmd_entry[mcb_pkg::STOP_BIT]) begin
        buffer_stop_o <= 1'b1;
      end else if (panel_i.start_pb) begin
        buffer_stop_o <= 1'b0;
      end
    end
  end

  // Repeat arms on the switch rising, so stop stays honoured while it is up
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      repeat_latch <= 1'b0;
      repeat_sw_q  <= 1'b0;
    end else begin
      repeat_sw_q <= panel_i.repeat_current_command;
      if (!panel_i.repeat_current_command || panel_i.stop_pb) begin
        repeat_latch <= 1'b0;
      end else if (!repeat_sw_q) begin
        repeat_latch <= 1'b1;
      end
    end
  end
  assign repeat_active_o = repeat_latch;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      display_a_o <= 8'h00;
      display_b_o <= 8'h00;
    end else begin
      display_a_o <= store[panel_i.left_rot][7:0];
      display_b_o <= {step_value, store[panel_i.left_rot][11:8]};
    end
  end

  // Microloop sequencer
  assign loop_sw = panel_i.counted_microloop || panel_i.address_bounded_microloop;

  always_comb begin
    next_state = state;
    case (state)
      mcb_pkg::L_IDLE:  if (loop_sw) next_state = mcb_pkg::L_RESET;
      mcb_pkg::L_RESET: next_state = panel_i.loop_delay_suppress ? mcb_pkg::L_LOAD
                                                                 : mcb_pkg::L_DELAY;
      mcb_pkg::L_DELAY: if (delay_count == 24'h000000) next_state = mcb_pkg::L_LOAD;
      mcb_pkg::L_LOAD:  next_state = mcb_pkg::L_RUN;
      mcb_pkg::L_RUN: begin
        if (count_mode && micro_i.ucycle && loop_count == mcb_pkg::CNT_RST) begin
          next_state = mcb_pkg::L_RESET;
        end else if (!count_mode && micro_i.microcode_address ==
                     {panel_i.left_rot, panel_i.right_rot}) begin
          next_state = mcb_pkg::L_RESET;
        end
      end
      default:          next_state = mcb_pkg::L_IDLE;
    endcase
    if (!loop_sw) begin
      next_state = mcb_pkg::L_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= mcb_pkg::L_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_mode  <= 1'b0;
      delay_count <= 24'h000000;
      loop_count  <= mcb_pkg::CNT_RST;
    end else begin
      if (state == mcb_pkg::L_IDLE) begin
        count_mode <= panel_i.counted_microloop;
      end
      if (state == mcb_pkg::L_RESET) begin
        delay_count <= DELAY_CYC - 24'h000001;
      end else if (state == mcb_pkg::L_DELAY) begin
        delay_count <= delay_count - 24'h000001;
      end
      if (state == mcb_pkg::L_LOAD) begin
        loop_count <= {panel_i.left_rot, panel_i.right_rot};
      end else if (state == mcb_pkg::L_RUN && micro_i.ucycle) begin
        loop_count <= loop_count - 12'h001;
      end
    end
  end

  assign machine_reset_o = (state == mcb_pkg::L_RESET);
  assign uaddr_load_o    = (state == mcb_pkg::L_LOAD);
  assign uaddr_value_o   = panel_i.start_uaddr;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 12'h000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        mcb_pkg::REG_HOLD:   reg_rdata_o <= buffer_output_holding_o;
        mcb_pkg::REG_CMDPTR: reg_rdata_o <= {8'h00, next_command_pointer};
        mcb_pkg::REG_CMDUB:  reg_rdata_o <= {8'h00, last_command_bound};
        mcb_pkg::REG_DATPTR: reg_rdata_o <= {8'h00, next_fetch_pointer};
        mcb_pkg::REG_DATLB:  reg_rdata_o <= {8'h00, fetch_lowest_bound};
        mcb_pkg::REG_PRESET: reg_rdata_o <= byte_count_preset;
        mcb_pkg::REG_COUNT:  reg_rdata_o <= byte_down_counter;
        mcb_pkg::REG_STATUS: reg_rdata_o <= {4'h0, state, repeat_latch, continuous,
                                             count_done_o, buffer_stop_o,
                                             miscompare_halt_o};
        default:             reg_rdata_o <= 12'h000;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_parity_odd;
    panel_wr && !panel_i.parity_corrupt |=> ^store[$past(panel_i.left_rot)][8:0];
  endproperty
  a_parity_odd: assert property (p_parity_odd) else $error("bad parity");

  property p_cmd_wrap;
    micro_i.access_command && !repeat_latch && !set_buf &&
    next_command_pointer == last_command_bound |=> next_command_pointer == 4'h0;
  endproperty
  a_cmd_wrap: assert property (p_cmd_wrap) else $error("no wrap");

  property p_data_wrap;
    fetch_go && !micro_i.access_command && !micro_i.read_bwd &&
    next_fetch_pointer == 4'hF |=> next_fetch_pointer == $past(fetch_lowest_bound);
  endproperty
  a_data_wrap: assert property (p_data_wrap) else $error("bad data wrap");

  property p_count_dec;
    fetch_go && !continuous && !micro_i.preset_to_counter
    |=> byte_down_counter == $past(byte_down_counter) - 12'h001;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("no count");

  property p_halt;
    miscompare |=> miscompare_halt_o ##1 $stable(buffer_output_holding_o);
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");

  property p_delay;
    state == mcb_pkg::L_RESET && loop_sw && !panel_i.loop_delay_suppress
    |=> state == mcb_pkg::L_DELAY && !uaddr_load_o;
  endproperty
  a_delay: assert property (p_delay) else $error("delay skipped");

  property p_addr_loop;
    state == mcb_pkg::L_RUN && !count_mode && loop_sw &&
    micro_i.microcode_address == {panel_i.left_rot, panel_i.right_rot}
    |=> machine_reset_o;
  endproperty
  a_addr_loop: assert property (p_addr_loop) else $error("no reset");

  property p_continuous;
    micro_i.preset_to_counter && byte_count_preset == 12'h000 |=> !count_done_o;
  endproperty
  a_continuous: assert property (p_continuous) else $error("ended");
endmodule : mcb_buffer

// ==== pkg/mcb_pkg.sv ====
package mcb_pkg;
  localparam int IDX_W   = 4;
  localparam int ENTRY_W = 12;
  localparam int DATA_W  = 8;
  localparam int CNT_W   = 12;
  localparam int UADDR_W = 12;
  localparam int DLY_W   = 24;
  localparam int NUM_ENTRIES = 16;

  // Entry layout
  localparam int PAR_BIT    = 8;
  localparam int STOP_BIT   = 9;
  localparam int UNIT_BIT   = 10;
  localparam int BRANCH_BIT = 11;

  localparam logic [IDX_W-1:0]   IDX_ZERO  = 4'h0;
  localparam logic [IDX_W-1:0]   DATA_TOP  = 4'hF;
  localparam logic [ENTRY_W-1:0] ENTRY_RST = 12'h000;
  localparam logic [CNT_W-1:0]   CNT_RST   = 12'h000;
  localparam logic [DATA_W-1:0]  BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0]  BYTE_ONES = 8'hFF;

  // Register port offsets
  localparam logic [3:0] REG_HOLD   = 4'h0;
  localparam logic [3:0] REG_CMDPTR = 4'h1;
  localparam logic [3:0] REG_CMDUB  = 4'h2;
  localparam logic [3:0] REG_DATPTR = 4'h3;
  localparam logic [3:0] REG_DATLB  = 4'h4;
  localparam logic [3:0] REG_PRESET = 4'h5;
  localparam logic [3:0] REG_COUNT  = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;

  // Loop delay
  localparam longint CLK_PERIOD_NS  = 8;
  localparam longint LOOP_DELAY_MS  = 100;
  localparam logic [DLY_W-1:0] LOOP_DELAY_CYC =
    DLY_W'(LOOP_DELAY_MS * 1000000 / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SRC_BUF  = 2'b00,
    SRC_ZERO = 2'b01,
    SRC_ONES = 2'b10
  } mcb_source_e;

  typedef enum logic [1:0] {
    BND_BUF       = 2'b00,
    BND_FETCH_LOW = 2'b01,
    BND_CMD_BOUND = 2'b10
  } mcb_bound_e;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_RESET = 3'b001,
    L_DELAY = 3'b010,
    L_LOAD  = 3'b011,
    L_RUN   = 3'b100
  } mcb_loop_e;

  typedef struct packed {
    logic [IDX_W-1:0]   left_rot;
    logic [DATA_W-1:0]  right_rot;
    logic [2:0]         flag_sw;
    logic [UADDR_W-1:0] start_uaddr;
    logic               count_or_entry_load_select;
    mcb_bound_e         bound_target_select;
    mcb_source_e        data_source;
    logic               halt_on_miscompare;
    logic               repeat_current_command;
    logic               counted_microloop;
    logic               address_bounded_microloop;
    logic               loop_delay_suppress;
    logic               parity_corrupt;
    logic               load_pb;
    logic               set_adr_pb;
    logic               stop_pb;
    logic               start_pb;
  } mcb_panel_s;

  typedef struct packed {
    logic               store_wr;
    logic               store_rd;
    logic [IDX_W-1:0]   store_idx;
    logic               hold_from_io;
    logic               access_command;
    logic               data_fetch;
    logic               preset_from_gc;
    logic               preset_to_counter;
    logic               count_dec;
    logic               read_fwd;
    logic               read_bwd;
    logic               ucycle;
    logic [UADDR_W-1:0] microcode_address;
  } mcb_micro_s;
endpackage : mcb_pkg

// ==== rtl/mcb_step_unit.sv ====
module mcb_step_unit (
  // Operand
  input  wire logic [mcb_pkg::IDX_W-1:0] value_i,
  input  wire logic                      cmd_i,
  input  wire logic                      down_i,
  // Bounds
  input  wire logic [mcb_pkg::IDX_W-1:0] cmd_bound_i,
  input  wire logic [mcb_pkg::IDX_W-1:0] data_low_i,
  // Result
  output logic      [mcb_pkg::IDX_W-1:0] next_o
);
  always_comb begin
    if (cmd_i) begin
      if (value_i == cmd_bound_i) begin
        next_o = mcb_pkg::IDX_ZERO;
      end else begin
        next_o = value_i + 4'h1;
      end
    end else if (down_i) begin
      if (value_i == data_low_i) begin
        next_o = mcb_pkg::DATA_TOP;
      end else begin
        next_o = value_i - 4'h1;
      end
    end else begin
      if (value_i == mcb_pkg::DATA_TOP) begin
        next_o = data_low_i;
      end else begin
        next_o = value_i + 4'h1;
      end
    end
  end
endmodule : mcb_step_unit

// ==== testbench/mcb_seq_model.sv ====
module mcb_seq_model (
  // Request from bench
  input  wire logic [2:0]         op_i,
  input  wire logic               go_i,
  input  wire logic [3:0]         idx_i,
  // Micro-orders
  output mcb_pkg::mcb_micro_s     micro_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One micro-order per request, data_fetch plus read_fwd for op 5, held only for the cycle of go_i
  always_comb begin
    micro_o           = '0;
    micro_o.store_idx = idx_i;
    if (go_i) begin
      case (op_i)
        3'h0: micro_o.access_command    = 1'b1;
        3'h1: micro_o.data_fetch        = 1'b1;
        3'h2: micro_o.preset_to_counter = 1'b1;
        3'h3: micro_o.store_wr          = 1'b1;
        3'h4: micro_o.store_rd          = 1'b1;
        3'h5: begin
          micro_o.data_fetch = 1'b1;
          micro_o.read_fwd   = 1'b1;
        end
        default: micro_o.ucycle         = 1'b1;
      endcase
    end
  end
endmodule : mcb_seq_model

// ==== testbench/mcb_buffer_tb_top.sv ====
module mcb_buffer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                sys_clk_i   = 1'b0;
  logic                rst_i       = 1'b1;
  logic [3:0]          reg_addr_i  = 4'h0;
  logic [11:0]         reg_wdata_i = 12'h000;
  logic                reg_wr_i    = 1'b0;
  logic                reg_rd_i    = 1'b0;
  logic                go          = 1'b0;
  logic [2:0]          op          = 3'h0;
  logic [11:0]         rdata, hold, srd;
  logic [11:0]         gc          = 12'h000;
  logic [7:0]          iob         = 8'h00;
  logic [7:0]          disp_a, disp_b;
  logic                mreset, uload, done;
  mcb_pkg::mcb_panel_s panel       = '0;
  mcb_pkg::mcb_micro_s micro;
  int                  err_count   = 0;
  int                  checks_done = 0;
  int                  cyc         = 0;

  mcb_buffer #(.DELAY_CYC(24'h000008)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .panel_i(panel), .micro_i(micro),
    .general_counter_i(gc), .io_byte_i(iob), .store_rd_data_o(srd),
    .buffer_output_holding_o(hold), .display_a_o(disp_a), .display_b_o(disp_b),
    .miscompare_halt_o(), .buffer_stop_o(), .count_done_o(done), .repeat_active_o(),
    .machine_reset_o(mreset), .uaddr_load_o(uload), .uaddr_value_o());
  mcb_seq_model seq_u (.op_i(op), .go_i(go), .idx_i(4'h0), .micro_o(micro));

  always #4 sys_clk_i = ~sys_clk_i;
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge sys_clk_i) reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [11:0] e);
    @(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge sys_clk_i) reg_rd_i <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd

  // Panel push-button; display lags the store by one more cycle
  task automatic pulse(input bit setadr);
    @(posedge sys_clk_i) {panel.set_adr_pb, panel.load_pb} <= {setadr, !setadr};
    @(posedge sys_clk_i) {panel.set_adr_pb, panel.load_pb} <= 2'b00;
    @(posedge sys_clk_i) #1;
  endtask : pulse

  task automatic seq(input logic [2:0] o);
    @(posedge sys_clk_i) {go, op} <= {1'b1, o};
    @(posedge sys_clk_i) go <= 1'b0;
    #1;
  endtask : seq

  task automatic await(input bit s);
    int n;
    n = 0;
    while ((s ? uload : mreset) !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    chk({11'h000, n < 20}, 12'h001);
  endtask : await

  task automatic t_reset;
    for (int a = 0; a < 9; a++) if (a != 7) rd(4'(a), 12'h000);
    rd(4'h7, 12'h004);
  endtask : t_reset

  task automatic t_load;
    @(posedge sys_clk_i) {panel.left_rot, panel.right_rot, panel.flag_sw} <= {4'h3, 8'h5A, 3'h5};
    pulse(1'b0);
    chk({4'h0, disp_a}, 12'h05A);
    chk({8'h00, disp_b[3:0]}, 12'h00B);
    @(posedge sys_clk_i) panel.parity_corrupt <= 1'b1;
    pulse(1'b0);
    chk({8'h00, disp_b[3:0]}, 12'h00A);
    @(posedge sys_clk_i) {panel.parity_corrupt, panel.count_or_entry_load_select} <= 2'b01;
    pulse(1'b0);
    rd(4'h5, 12'h35A);
    @(posedge sys_clk_i) panel.count_or_entry_load_select <= 1'b0;
  endtask : t_load

  task automatic t_bounds;
    mcb_pkg::mcb_bound_e b[3] = '{mcb_pkg::BND_BUF, mcb_pkg::BND_FETCH_LOW,
                                  mcb_pkg::BND_CMD_BOUND};
    logic [3:0] r[3] = '{4'h1, 4'h4, 4'h2};
    logic [3:0] v[3] = '{4'h9, 4'hE, 4'h1};
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i);
      panel.bound_target_select <= b[i];
      panel.left_rot            <= v[i];
      pulse(1'b1);
      if (i == 0) chk({8'h00, disp_b[7:4]}, 12'h009);
      rd(r[i], {8'h00, v[i]});
    end
  endtask : t_bounds

  task automatic t_cmd;
    wr(4'h1, 12'h003);
    wr(4'h2, 12'h003);
    seq(3'h0);
    chk(hold, 12'hA5A);
    rd(4'h1, 12'h000);
    rd(4'h7, 12'h006);
    seq(3'h0);
    rd(4'h1, 12'h001);
    @(posedge sys_clk_i) panel.repeat_current_command <= 1'b1;
    seq(3'h0);
    rd(4'h1, 12'h001);
    @(posedge sys_clk_i) panel.repeat_current_command <= 1'b0;
  endtask : t_cmd

  task automatic t_fetch;
    wr(4'h3, 12'h00F);
    wr(4'h5, 12'h002);
    seq(3'h2);
    rd(4'h6, 12'h002);
    seq(3'h1);
    rd(4'h3, 12'h00E);
    rd(4'h6, 12'h001);
    seq(3'h1);
    rd(4'h3, 12'h00F);
    chk({11'h000, done}, 12'h001);
    seq(3'h1);
    rd(4'h3, 12'h00F);
  endtask : t_fetch

  task automatic t_seqio;
    @(posedge sys_clk_i) gc <= 12'h2C3;
    seq(3'h3);
    seq(3'h4);
    chk(hold, 12'h3C3);
    chk(srd, 12'h3C3);
    wr(4'h5, 12'h000);
    seq(3'h2);
    rd(4'h7, 12'h00A);
    @(posedge sys_clk_i);
    panel.halt_on_miscompare <= 1'b1;
    panel.data_source        <= mcb_pkg::SRC_ONES;
    iob                      <= 8'hFF;
    seq(3'h5);
    chk(hold, 12'h1FF);
    rd(4'h7, 12'h00A);
    @(posedge sys_clk_i) panel.data_source <= mcb_pkg::SRC_ZERO;
    seq(3'h5);
    chk(hold, 12'h100);
    rd(4'h7, 12'h00B);
  endtask : t_seqio

  task automatic t_loop;
    @(posedge sys_clk_i) {panel.loop_delay_suppress, panel.counted_microloop} <= 2'b11;
    await(1'b0);
    await(1'b1);
    @(posedge sys_clk_i) panel.counted_microloop <= 1'b0;
    @(posedge sys_clk_i);
    {panel.left_rot, panel.right_rot} <= 12'h000;
    {panel.loop_delay_suppress, panel.address_bounded_microloop} <= 2'b01;
    await(1'b0);
    await(1'b1);
    await(1'b0);
    @(posedge sys_clk_i) panel.address_bounded_microloop <= 1'b0;
  endtask : t_loop

  task automatic conclude;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_load();
    t_bounds();
    t_cmd();
    t_fetch();
    t_seqio();
    t_loop();
    conclude();
  end
endmodule : mcb_buffer_tb_top
